// [ebc_pkg.sv]
// shared constants, state record and reset values of the expansion
// bus configuration block; assumes one 50 MHz clock and wishbone regs
// Summary of operation
// - single chip: ports A, B general purpose
// - single chip: PE1/PE0 pulled inputs, others general purpose
// - single chip: PE bus functions blocked except PE4 clock, enables other than clock disable ignored
// - normal single chip mode register writes once
// - single chip: clock disable cleared gives PE4 clock
// - wide modes: A/B 16-bit muxed bus, PE4 clock
// - normal wide: PE control pins other than the PE4 clock start as GPIO
// - pipe enable puts pipe status on PE6/PE5
// - rw enable makes PE2 the read/write output
// - normal wide: strobe enable makes PE3 strobe
// - expanded: PE4 stretched clock, gated by settings
// - normal narrow: data on A only, no visibility
// - normal narrow: assignment register writes once
// - normal narrow: PE3 always GPIO, strobe overridden
// - visibility only wide, test, emulation narrow modes
// - invisible internal cycle: clock low, rw high, hold
// - visible debug cycle: rw high, address driven, data held
// - visible no-access cycle: rw high, pins held
// - emulation: PE7..PE2 all bus control outputs
// - narrow: external words split into two bytes
// - narrow byte lanes: PA7, PB0, PA0 mapping
// - emulation narrow internal 16-bit only when visible
// - mode pins latched at reset release
// - reset sets clock stretch bit
package ebc_pkg;
    localparam logic [3:0] ADR_MODE = 4'h0;
    localparam logic [3:0] ADR_PORT_E_ASSIGN = 4'h4;
    localparam logic [3:0] ADR_EXT_BUS_CTRL = 4'h8;
    localparam logic [3:0] ADR_STATUS = 4'hc;
    // field positions in the mode, assignment and bus control registers
    localparam int MODE_LSB = 5;
    localparam int INTERNAL_VISIBILITY_BIT_BIT = 3;
    localparam int PIPE_BIT = 5;
    localparam int CLKDIS_BIT = 4;
    localparam int LSTR_BIT = 3;
    localparam int RW_BIT = 2;
    localparam int STRETCH_BIT = 0;
    localparam logic [2:0] M_SSC = 3'h0;
    localparam logic [2:0] M_EMU_NAR = 3'h1;
    localparam logic [2:0] M_TEST = 3'h2;
    localparam logic [2:0] M_EMU_WIDE = 3'h3;
    localparam logic [2:0] M_NSC = 3'h4;
    localparam logic [2:0] M_NRM_NAR = 3'h5;
    localparam logic [2:0] M_PERIPH = 3'h6;
    localparam logic [2:0] M_NRM_WIDE = 3'h7;
    localparam int BUS_CLOCK_OUT_HALF_CYC = 4;
    typedef struct packed {
        logic [2:0] msync1, msync2;
        logic [7:0] async1, async2, bsync1, bsync2;
        logic latched, internal_visibility_bit, mode_wr_done, port_e_assign_reg_wr_done, bus_clock_stretch_bit;
        logic [2:0] mode;
        logic pipe_en, clk_dis, lstr_en, rw_en;
        logic ack;
        logic [31:0] rdat;
        logic [3:0] cnt;
        logic phase, busy, half;
        logic intl, background_debug, no_access_flag, wr, word, map, low_byte_strobe;
        logic [15:0] addr, wdata, rd_data;
        logic done;
        logic [7:0] pa, pa_oe_n, pb, pb_oe_n, pe, pe_oe_n, pe_pu;
    } ebc_state_t;
    localparam ebc_state_t ST_RESET = '{
        pa_oe_n: 8'hff, pb_oe_n: 8'hff, pe_oe_n: 8'hff, pe_pu: 8'hff,
        bus_clock_stretch_bit: 1'b1, default: '0};
endpackage

// [ebc_top.sv]
// port function selection and multiplexed bus cycles of the expansion
// bus; assumes wishbone registers, pins synced here, same-clock requests
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ebc_top #(
    parameter int HALF_CYC = ebc_pkg::BUS_CLOCK_OUT_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic mode_sel_c_i,
    input wire logic mode_sel_b_i,
    input wire logic mode_sel_a_i,
    input wire logic acc_req_i,
    input wire logic acc_int_i,
    input wire logic acc_bdm_i,
    input wire logic acc_no_access_flag_i,
    input wire logic acc_map_i,
    input wire logic acc_wr_i,
    input wire logic acc_word_i,
    input wire logic acc_low_byte_strobe_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic [15:0] acc_data_i,
    input wire logic [1:0] pipe_status_i,
    output logic acc_done_o,
    output logic [15:0] acc_rdata_o,
    input wire logic [7:0] gpio_a_i,
    input wire logic [7:0] gpio_a_oe_n_i,
    input wire logic [7:0] gpio_b_i,
    input wire logic [7:0] gpio_b_oe_n_i,
    input wire logic [7:0] gpio_e_i,
    input wire logic [7:0] gpio_e_oe_n_i,
    input wire logic [7:0] pa_i,
    input wire logic [7:0] pb_i,
    output logic [7:0] pa_o,
    output logic [7:0] pa_oe_n_o,
    output logic [7:0] pb_o,
    output logic [7:0] pb_oe_n_o,
    output logic [7:0] pe_o,
    output logic [7:0] pe_oe_n_o,
    output logic [7:0] pe_pullup_o
);
    localparam logic [3:0] LIM_N = 4'(HALF_CYC - 1);
    localparam logic [3:0] LIM_S = 4'(2 * HALF_CYC - 1);

    function automatic logic is_exp(input logic [2:0] m);
        return m == ebc_pkg::M_EMU_NAR || m == ebc_pkg::M_TEST ||
            m == ebc_pkg::M_EMU_WIDE || m == ebc_pkg::M_NRM_NAR ||
            m == ebc_pkg::M_NRM_WIDE;
    endfunction
    function automatic logic is_wide(input logic [2:0] m);
        return m == ebc_pkg::M_TEST || m == ebc_pkg::M_EMU_WIDE ||
            m == ebc_pkg::M_NRM_WIDE;
    endfunction
    function automatic logic is_emu(input logic [2:0] m);
        return m == ebc_pkg::M_EMU_NAR || m == ebc_pkg::M_EMU_WIDE;
    endfunction
    function automatic logic is_single(input logic [2:0] m);
        return m == ebc_pkg::M_SSC || m == ebc_pkg::M_NSC;
    endfunction
    // visibility only where the internal cycle fits one bus cycle
    function automatic logic vis_ok(input ebc_pkg::ebc_state_t t);
        return t.internal_visibility_bit && (is_wide(t.mode) ||
            t.mode == ebc_pkg::M_EMU_NAR);
    endfunction
    // alternate functions of PE7..PE2, mode forcing first
    function automatic logic [7:0] alt_fn(input ebc_pkg::ebc_state_t t);
        logic e;
        logic x;
        e = is_emu(t.mode);
        x = is_exp(t.mode);
        alt_fn = '0;
        alt_fn[7] = e;
        alt_fn[6] = e | (x & t.pipe_en);
        alt_fn[5] = alt_fn[6];
        alt_fn[4] = e | ((x | is_single(t.mode)) & ~t.clk_dis);
        alt_fn[3] = e | (is_wide(t.mode) & t.lstr_en);
        alt_fn[2] = e | (x & t.rw_en);
    endfunction

    ebc_pkg::ebc_state_t s_r, s_nxt;
    logic acc_wr, blk_r, upd_addr, upd_data, visible, narrow8;
    logic [7:0] fn;
    logic [7:0] fn_cur;
    logic [3:0] lim;
    logic [2:0] wmode;

    always_comb begin
        s_nxt = s_r;
        fn = '0;
        wmode = 3'h0;
        visible = 1'b0;
        upd_addr = 1'b0;
        upd_data = 1'b0;
        narrow8 = 1'b0;
        s_nxt.ack = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.msync1 = {mode_sel_c_i, mode_sel_b_i, mode_sel_a_i};
        s_nxt.msync2 = s_r.msync1;
        s_nxt.async1 = pa_i;
        s_nxt.async2 = s_r.async1;
        s_nxt.bsync1 = pb_i;
        s_nxt.bsync2 = s_r.bsync1;
        // first cycle after release: capture mode and its defaults
        if (!s_r.latched) begin
            s_nxt.latched = 1'b1;
            s_nxt.mode = s_r.msync2;
            s_nxt.bus_clock_stretch_bit = 1'b1;
            s_nxt.internal_visibility_bit = s_r.msync2 == ebc_pkg::M_EMU_NAR ||
                s_r.msync2 == ebc_pkg::M_TEST ||
                s_r.msync2 == ebc_pkg::M_EMU_WIDE;
            s_nxt.clk_dis = is_single(s_r.msync2);
            s_nxt.pipe_en = is_emu(s_r.msync2);
            s_nxt.lstr_en = is_emu(s_r.msync2);
            s_nxt.rw_en = is_emu(s_r.msync2);
        end
        // register bus: one wait state, ack drops after one cycle
        acc_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~s_r.ack & wb_sel_i[0]
            & s_r.latched;
        if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
            s_nxt.ack = 1'b1;
        end
        wmode = wb_dat_i[ebc_pkg::MODE_LSB +: 3];
        if (acc_wr && wb_adr_i == ebc_pkg::ADR_MODE) begin
            case (s_r.mode)
                ebc_pkg::M_NSC: begin
                    if (!s_r.mode_wr_done) begin
                        s_nxt.mode_wr_done = 1'b1;
                        s_nxt.internal_visibility_bit = wb_dat_i[ebc_pkg::INTERNAL_VISIBILITY_BIT_BIT];
                        if (wmode[1:0] != 2'h2) begin
                            s_nxt.mode = {1'b1, wmode[1:0]};
                        end
                    end
                end
                ebc_pkg::M_SSC, ebc_pkg::M_TEST: begin
                    s_nxt.internal_visibility_bit = wb_dat_i[ebc_pkg::INTERNAL_VISIBILITY_BIT_BIT];
                    if (wmode != ebc_pkg::M_PERIPH) begin
                        s_nxt.mode = wmode;
                    end
                end
                ebc_pkg::M_NRM_NAR, ebc_pkg::M_NRM_WIDE: begin
                    if (!s_r.mode_wr_done) begin
                        s_nxt.mode_wr_done = 1'b1;
                        s_nxt.internal_visibility_bit = wb_dat_i[ebc_pkg::INTERNAL_VISIBILITY_BIT_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
        // emulation keeps its forced enables; narrow allows one write
        if (acc_wr && wb_adr_i == ebc_pkg::ADR_PORT_E_ASSIGN &&
                !is_emu(s_r.mode) && s_r.mode != ebc_pkg::M_PERIPH &&
                !(s_r.mode == ebc_pkg::M_NRM_NAR && s_r.port_e_assign_reg_wr_done)) begin
            s_nxt.port_e_assign_reg_wr_done = 1'b1;
            s_nxt.pipe_en = wb_dat_i[ebc_pkg::PIPE_BIT];
            s_nxt.clk_dis = wb_dat_i[ebc_pkg::CLKDIS_BIT];
            s_nxt.lstr_en = wb_dat_i[ebc_pkg::LSTR_BIT];
            s_nxt.rw_en = wb_dat_i[ebc_pkg::RW_BIT];
        end
        if (acc_wr && wb_adr_i == ebc_pkg::ADR_EXT_BUS_CTRL) begin
            s_nxt.bus_clock_stretch_bit = wb_dat_i[ebc_pkg::STRETCH_BIT];
        end
        case (wb_adr_i)
            ebc_pkg::ADR_MODE: s_nxt.rdat = 32'({s_r.mode, 1'b0,
                s_r.internal_visibility_bit, 3'h0});
            ebc_pkg::ADR_PORT_E_ASSIGN: s_nxt.rdat = 32'({s_r.pipe_en,
                s_r.clk_dis, s_r.lstr_en, s_r.rw_en, 2'h0});
            ebc_pkg::ADR_EXT_BUS_CTRL: s_nxt.rdat = 32'(s_r.bus_clock_stretch_bit);
            ebc_pkg::ADR_STATUS: s_nxt.rdat = 32'({vis_ok(s_r),
                s_r.busy, alt_fn(s_r)});
            default: s_nxt.rdat = 32'h0;
        endcase
        // bus clock phases; external high phase doubled when stretched
        lim = (s_r.phase && s_r.busy && !s_r.intl && s_r.bus_clock_stretch_bit) ?
            LIM_S : LIM_N;
        visible = vis_ok(s_r);
        upd_addr = !s_r.intl || (visible && !(s_r.no_access_flag && !s_r.background_debug));
        upd_data = !s_r.intl || (visible && !s_r.background_debug && !s_r.no_access_flag);
        narrow8 = !is_wide(s_r.mode) && !s_r.intl && !s_r.map;
        if (s_r.cnt != lim) begin
            s_nxt.cnt = s_r.cnt + 4'h1;
        end else begin
            s_nxt.cnt = 4'h0;
            s_nxt.phase = ~s_r.phase;
            if (!s_r.phase && s_r.busy && upd_data) begin
                if (s_r.wr) begin
                    s_nxt.pa = (narrow8 && (s_r.half || !s_r.word)) ?
                        s_r.wdata[7:0] : s_r.wdata[15:8];
                    if (!narrow8) begin
                        s_nxt.pb = s_r.wdata[7:0];
                    end
                end else begin
                    s_nxt.pa_oe_n = 8'hff;
                    s_nxt.pb_oe_n = narrow8 ? 8'h00 : 8'hff;
                end
            end else if (s_r.phase) begin
                if (s_r.busy) begin
                    if (!s_r.wr && !s_r.intl) begin
                        if (!narrow8) begin
                            s_nxt.rd_data = {s_r.async2, s_r.bsync2};
                        end else if (s_r.word && !s_r.half) begin
                            s_nxt.rd_data[15:8] = s_r.async2;
                        end else begin
                            s_nxt.rd_data[7:0] = s_r.async2;
                        end
                    end
                    if (narrow8 && s_r.word && !s_r.half) begin
                        s_nxt.half = 1'b1;
                        s_nxt.addr = s_r.addr + 16'h1;
                        s_nxt.pa = s_r.addr[15:8];
                        s_nxt.pb = s_r.addr[7:0] + 8'h1;
                        s_nxt.pa_oe_n = 8'h00;
                    end else begin
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                    end
                end else if (acc_req_i && is_exp(s_r.mode)) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.half = 1'b0;
                    s_nxt.intl = acc_int_i;
                    s_nxt.background_debug = acc_bdm_i;
                    s_nxt.no_access_flag = acc_no_access_flag_i;
                    s_nxt.map = acc_map_i;
                    s_nxt.wr = acc_wr_i;
                    s_nxt.word = acc_word_i;
                    s_nxt.addr = acc_addr_i;
                    s_nxt.wdata = acc_data_i;
                    if (!acc_int_i || (visible &&
                            !(acc_no_access_flag_i && !acc_bdm_i))) begin
                        s_nxt.pa = acc_addr_i[15:8];
                        s_nxt.pb = acc_addr_i[7:0];
                        s_nxt.pa_oe_n = 8'h00;
                        s_nxt.pb_oe_n = 8'h00;
                        s_nxt.low_byte_strobe = acc_low_byte_strobe_i;
                    end
                end
            end
        end
        // pin multiplexing from the next state so pins match the state
        fn = alt_fn(s_nxt);
        if (!is_exp(s_nxt.mode)) begin
            s_nxt.pa = gpio_a_i;
            s_nxt.pa_oe_n = gpio_a_oe_n_i;
            s_nxt.pb = gpio_b_i;
            s_nxt.pb_oe_n = gpio_b_oe_n_i;
        end
        s_nxt.pe = gpio_e_i;
        s_nxt.pe_oe_n = gpio_e_oe_n_i | 8'h03;
        blk_r = s_nxt.busy && (!s_nxt.wr || (s_nxt.intl &&
            !(vis_ok(s_nxt) && !s_nxt.background_debug && !s_nxt.no_access_flag)));
        s_nxt.pe[7] = s_nxt.busy & s_nxt.no_access_flag;
        s_nxt.pe[6:5] = pipe_status_i;
        s_nxt.pe[4] = s_nxt.phase &
            ~(s_nxt.busy & s_nxt.intl & ~vis_ok(s_nxt));
        s_nxt.pe[3] = s_nxt.low_byte_strobe;
        s_nxt.pe[2] = blk_r || !s_nxt.busy;
        for (int i = 2; i < 8; i++) begin
            if (fn[i]) begin
                s_nxt.pe[i] = s_nxt.pe[i];
                s_nxt.pe_oe_n[i] = 1'b0;
            end else begin
                s_nxt.pe[i] = gpio_e_i[i];
            end
        end
        // pullups only on pins left as undriven general purpose
        s_nxt.pe_pu = s_nxt.pe_oe_n & ~fn | 8'h03;
        if (rst_i) begin
            s_nxt = ebc_pkg::ST_RESET;
            s_nxt.msync1 = {mode_sel_c_i, mode_sel_b_i, mode_sel_a_i};
            s_nxt.msync2 = s_r.msync1;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.rdat;
    assign acc_done_o = s_r.done;
    assign acc_rdata_o = s_r.rd_data;
    assign pa_o = s_r.pa;
    assign pa_oe_n_o = s_r.pa_oe_n;
    assign pb_o = s_r.pb;
    assign pb_oe_n_o = s_r.pb_oe_n;
    assign pe_o = s_r.pe;
    assign pe_oe_n_o = s_r.pe_oe_n;
    assign pe_pullup_o = s_r.pe_pu;
    // current pin functions, so checks need no select on a call
    assign fn_cur = alt_fn(s_r);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    single_gpio_a: assert property (
        (s_r.latched && is_single(s_r.mode) && $stable(s_r.mode))
        |-> pa_o == $past(gpio_a_i) && pb_oe_n_o == $past(gpio_b_oe_n_i))
        else $error("single chip port A/B not general purpose");
    pe_low_in_a: assert property (
        s_r.latched |-> pe_oe_n_o[1:0] == 2'h3 && pe_pullup_o[1:0] == 2'h3)
        else $error("PE1/PE0 not pulled inputs");
    single_alt_a: assert property (
        (is_single(s_r.mode) && $stable(s_r.mode) && s_r.latched)
        |-> pe_oe_n_o[3:2] == $past(gpio_e_oe_n_i[3:2]))
        else $error("bus function on PE3/PE2 in single chip");
    mode_once_a: assert property (
        $past(s_r.mode_wr_done) |-> s_r.mode == $past(s_r.mode))
        else $error("mode changed after its one write");
    narrow_strobe_a: assert property (
        (s_r.mode == ebc_pkg::M_NRM_NAR && $stable(s_r.mode))
        |-> pe_oe_n_o[3] == $past(gpio_e_oe_n_i[3]))
        else $error("strobe enabled in normal narrow mode");
    invis_clk_a: assert property (
        (s_r.busy && s_r.intl && !vis_ok(s_r) && fn_cur[4])
        |-> !pe_o[4] && (!fn_cur[2] || pe_o[2]))
        else $error("invisible cycle reached the bus");
    dbg_rw_a: assert property (
        (s_r.busy && s_r.intl && (s_r.background_debug || s_r.no_access_flag) && fn_cur[2])
        |-> pe_o[2])
        else $error("read/write low in blocked cycle");
    pipe_out_a: assert property (
        (fn_cur[6] && $stable(s_r.pipe_en) && $stable(s_r.mode))
        |-> pe_o[6:5] == $past(pipe_status_i) && !pe_oe_n_o[6])
        else $error("pipe status not on PE6/PE5");
    emu_ctrl_a: assert property (
        (is_emu(s_r.mode) && s_r.latched) |-> pe_oe_n_o[7:2] == 6'h00)
        else $error("emulation control pin not driven");
    stretch_a: assert property (
        $rose(s_r.latched) |-> s_r.bus_clock_stretch_bit)
        else $error("stretch bit clear after reset");
    split_a: assert property (
        (s_r.busy && narrow8 && s_r.word && s_r.phase && s_r.cnt == lim
        && !s_r.half) |=> s_r.busy && s_r.half && !acc_done_o)
        else $error("narrow word not split");
    wb_ack_a: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not one cycle");

    cov_wide_wr_c: cover property (acc_done_o && s_r.wr &&
        is_wide(s_r.mode));
    cov_split_c: cover property (acc_done_o && s_r.half);
    cov_invis_c: cover property (s_r.busy && s_r.intl && !vis_ok(s_r));
    cov_mode_wr_c: cover property ($rose(s_r.mode_wr_done));
endmodule
`default_nettype wire

// [ebc_ext_mem.sv]
// external 16-bit memory on the multiplexed bus of ports A and B
// assumes address on pa/pb while bus clock is low, read when pa released
`timescale 1ns/1ps
`default_nettype none
module ebc_ext_mem (
    input wire logic clk_i,
    input wire logic bus_clk_i,
    input wire logic [7:0] pa_drv_i,
    input wire logic [7:0] pa_oe_n_i,
    input wire logic [7:0] pb_drv_i,
    input wire logic [7:0] pb_oe_n_i,
    output logic [7:0] pa_rd_o,
    output logic [7:0] pb_rd_o
);
    logic [15:0] addr_r;
    logic [7:0] pa_last_r;
    logic [7:0] pb_last_r;
    // data is a fixed function of the address, so the bench can predict it
    assign pa_rd_o = (bus_clk_i && pa_oe_n_i == 8'hff) ?
        (addr_r[7:0] ^ 8'h5a) : ~pa_last_r;
    // lanes not released while the bus clock is high toggle every cycle so stale data never looks valid
    assign pb_rd_o = (bus_clk_i && pb_oe_n_i == 8'hff) ?
        (addr_r[15:8] ^ 8'ha5) : ~pb_last_r;
    always @(posedge clk_i) begin
        if (!bus_clk_i) begin
            addr_r <= {pa_drv_i, pb_drv_i};
        end
        pa_last_r <= pa_rd_o;
        pb_last_r <= pb_rd_o;
    end
endmodule
`default_nettype wire

// [test_ebc_top.sv]
// self-checking bench of the expansion bus configuration block
// assumes the external memory model answers on ports A and B
`timescale 1ns/1ps
`default_nettype none
module test_ebc_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [2:0] mode_pins = 3'h4;
    logic req = 1'b0, intl = 1'b0, word = 1'b0, background_debug = 1'b0, wr = 1'b0;
    logic [15:0] aaddr = 16'h0, wd16 = 16'h0, rdata;
    logic [7:0] gpa = 8'h0, gpa_oe_n = 8'hff, gpe_oe_n = 8'hff;
    logic [7:0] pa_in, pb_in, pa_o, pa_oe_n_o, pb_o, pb_oe_n_o;
    logic [7:0] pe_o, pe_oe_n_o, pe_pullup_o;
    logic ack, acc_done_o;
    int bad_count = 0, comparisons = 0, cycles = 0;

    ebc_top u_ebc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .mode_sel_c_i(mode_pins[2]), .mode_sel_b_i(mode_pins[1]),
        .mode_sel_a_i(mode_pins[0]), .acc_req_i(req), .acc_int_i(intl),
        .acc_bdm_i(background_debug), .acc_no_access_flag_i(1'b0), .acc_map_i(1'b0),
        .acc_wr_i(wr), .acc_word_i(word), .acc_low_byte_strobe_i(1'b0),
        .acc_addr_i(aaddr), .acc_data_i(wd16), .pipe_status_i(2'h1),
        .acc_done_o(acc_done_o), .acc_rdata_o(rdata), .gpio_a_i(gpa),
        .gpio_a_oe_n_i(gpa_oe_n), .gpio_b_i(~gpa), .gpio_b_oe_n_i(gpa_oe_n),
        .gpio_e_i(gpa), .gpio_e_oe_n_i(gpe_oe_n), .pa_i(pa_in),
        .pb_i(pb_in), .pa_o(pa_o), .pa_oe_n_o(pa_oe_n_o), .pb_o(pb_o),
        .pb_oe_n_o(pb_oe_n_o), .pe_o(pe_o), .pe_oe_n_o(pe_oe_n_o),
        .pe_pullup_o(pe_pullup_o));
    ebc_ext_mem u_ebc_ext_mem (.clk_i(clk_i), .bus_clk_i(pe_o[4]),
        .pa_drv_i(pa_o), .pa_oe_n_i(pa_oe_n_o), .pb_drv_i(pb_o),
        .pb_oe_n_i(pb_oe_n_o), .pa_rd_o(pa_in), .pb_rd_o(pb_in));

    always #10 clk_i = ~clk_i;

    task automatic end_sim;
        $display("counts: %0d bad, %0d compared", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // the whole run needs a few hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // look at ack mid-cycle, where it has settled
        @(negedge clk_i);
        while (ack !== 1'b1) begin
            @(negedge clk_i);
        end
        rdat = dat_o;
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic do_reset(input logic [2:0] m);
        @(posedge clk_i);
        rst_i <= 1'b1;
        mode_pins <= m;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // n reaches 200 when the request is never taken
    task automatic acc(input logic in, input logic [15:0] a, output int n,
            output logic held);
        logic [7:0] pa0;
        n = 0;
        held = 1'b1;
        @(posedge clk_i);
        req <= 1'b1;
        intl <= in;
        aaddr <= a;
        word <= 1'b1;
        @(negedge clk_i);
        pa0 = pa_o;
        while (acc_done_o !== 1'b1 && n < 200) begin
            if (pe_o[2] !== 1'b1 || (in && pa_o !== pa0)) begin
                held = 1'b0;
            end
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
        req <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic t_single;
        int n;
        int hi;
        logic h;
        gpa <= 8'h3c;
        gpa_oe_n <= 8'h0f;
        gpe_oe_n <= 8'h00;
        repeat (3) @(posedge clk_i);
        chk(32'(pa_o), 32'h3c);
        chk(32'(pa_oe_n_o), 32'h0f);
        chk(32'(pe_oe_n_o[1:0]), 32'h3);
        chk(32'(pe_pullup_o[1:0]), 32'h3);
        wb(1'b0, ebc_pkg::ADR_MODE, 32'h0);
        chk(32'(rdat[7:5]), 32'h4);
        wb(1'b0, ebc_pkg::ADR_EXT_BUS_CTRL, 32'h0);
        chk(32'(rdat[0]), 32'h1);
        wb(1'b0, 4'h2, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b1, ebc_pkg::ADR_PORT_E_ASSIGN, 32'h2c);
        wb(1'b0, ebc_pkg::ADR_STATUS, 32'h0);
        chk(32'(rdat[7:0] & 8'hec), 32'h0);
        chk(32'(rdat[4]), 32'h1);
        hi = 0;
        repeat (40) begin
            @(posedge clk_i);
            hi += (pe_o[4] === 1'b1) ? 1 : 0;
        end
        chk(32'(hi > 0 && hi < 40), 32'h1);
        acc(1'b0, 16'h1234, n, h);
        chk(32'(n), 32'd200);
        wb(1'b1, ebc_pkg::ADR_MODE, 32'he0);
        wb(1'b0, ebc_pkg::ADR_MODE, 32'h0);
        chk(32'(rdat[7:5]), 32'h7);
        wb(1'b1, ebc_pkg::ADR_MODE, 32'ha0);
        wb(1'b0, ebc_pkg::ADR_MODE, 32'h0);
        chk(32'(rdat[7:5]), 32'h7);
        $display("single chip test over");
    endtask

    task automatic t_wide;
        int n;
        logic h;
        acc(1'b0, 16'h1234, n, h);
        chk(32'(rdata), 32'h6eb7);
        chk(32'(h), 32'h1);
        wb(1'b0, ebc_pkg::ADR_STATUS, 32'h0);
        chk(32'(rdat[7:0] & 8'h7c), 32'h7c);
        acc(1'b1, 16'h0800, n, h);
        chk(32'(h), 32'h1);
        chk(32'(n < 200), 32'h1);
        $display("wide test over");
    endtask

    task automatic t_narrow;
        int n;
        logic h;
        do_reset(3'h5);
        wb(1'b1, ebc_pkg::ADR_PORT_E_ASSIGN, 32'h0c);
        wb(1'b1, ebc_pkg::ADR_PORT_E_ASSIGN, 32'h00);
        wb(1'b0, ebc_pkg::ADR_STATUS, 32'h0);
        chk(32'(rdat[3]), 32'h0);
        chk(32'(rdat[2]), 32'h1);
        chk(32'(rdat[9]), 32'h0);
        acc(1'b0, 16'h2000, n, h);
        chk(32'(rdata), 32'h5a5b);
        $display("narrow test over");
    endtask

    initial begin
        do_reset(3'h4);
        t_single();
        t_wide();
        t_narrow();
        end_sim();
    end
endmodule
`default_nettype wire
